// file: ewag_regs.svh
`ifndef EWAG_REGS_SVH
`define EWAG_REGS_SVH

// register byte offsets
`define EWAG_CTRL_OFS      12'h000
`define EWAG_STATUS_OFS    12'h004
`define EWAG_LAST_EA_OFS   12'h008
`define EWAG_LAST_IMP_OFS  12'h00C
`define EWAG_DONE_CNT_OFS  12'h010

// control fields and reset values
`define EWAG_CTRL_LEGACY_BIT  0
`define EWAG_CTRL_ENABLE_BIT  1
`define EWAG_LEGACY_RST       1'b0
`define EWAG_ENABLE_RST       1'b1

// status fields
`define EWAG_STAT_BUSY_BIT    0
`define EWAG_STAT_IND_BIT     1

// extension word field positions
`define EWAG_EXT_IDX_LONG     11
`define EWAG_EXT_SCALE_HI     10
`define EWAG_EXT_SCALE_LO     9
`define EWAG_EXT_FULL         8
`define EWAG_EXT_BASE_SUPP    7
`define EWAG_EXT_IDX_SUPP     6
`define EWAG_EXT_BD_HI        5
`define EWAG_EXT_BD_LO        4
`define EWAG_EXT_IIS_HI       2
`define EWAG_EXT_IIS_LO       0

// effective-address field code for program-relative base
`define EWAG_EA_PC_REL        6'h3B

`endif

// file: ewag_pkg.sv
package ewag_pkg;

	typedef enum logic [3:0]
	{
		S_IDLE  = 4'b0001,
		S_CALC  = 4'b0010,
		S_FETCH = 4'b0100,
		S_DONE  = 4'b1000
	} ewag_state_e;

	typedef enum logic [1:0]
	{
		SZ_NULL = 2'b00,
		SZ_BYTE = 2'b01,
		SZ_WORD = 2'b10,
		SZ_LONG = 2'b11
	} ewag_size_e;

	typedef struct packed
	{
		logic [5:0]  eaField;
		logic [15:0] extWord;
		logic [31:0] addressRegBase;
		logic [31:0] indexOperand;
		logic [31:0] baseDisplacement;
		logic [31:0] outerDisplacement;
		logic [31:0] extPc;
	} ewag_req_s;

	typedef struct packed
	{
		ewag_state_e st;
		ewag_req_s   req;
		logic        legacy;
		logic        enable;
		logic        memReq;
		logic [31:0] memAddr;
		logic [31:0] ea;
		logic [31:0] intermediate_pointer;
		logic        lastInd;
		logic [31:0] rdata;
		logic        slverr;
		logic [15:0] doneCnt;
	} ewag_state_s;

endpackage

// file: ewag_elem_sizer.sv
`timescale 1ns/1ps
module ewag_elem_sizer #(
	parameter int W = 32
) (
	input  wire logic [W-1:0]        raw,
	input  wire ewag_pkg::ewag_size_e sel,
	output logic      [W-1:0]        val
);

	if (W < 16)
	begin
		$error("ewag_elem_sizer: W must be at least 16");
	end

	// null or suppressed elements add nothing; short ones sign-extend
	always_comb
	begin
		case (sel)
			ewag_pkg::SZ_NULL: val = '0;
			ewag_pkg::SZ_BYTE: val = {{(W-8){raw[7]}}, raw[7:0]};
			ewag_pkg::SZ_WORD: val = {{(W-16){raw[15]}}, raw[15:0]};
			ewag_pkg::SZ_LONG: val = raw;
			default:           val = '0;
		endcase
	end

endmodule

// file: ewag_core.sv
`timescale 1ns/1ps
`include "ewag_regs.svh"
// Overview of operation
// - a zero scale field decodes the same in old and new brief formats
// - legacy core mode ignores any nonzero scale, giving an unscaled address
// - unknown extension encodings raise no exception; they decode quietly
// - base, index, base and outer displacement each suppressible; suppressed adds zero
// - base suppress forces the base operand to zero
// - effective-address field picks program counter or address register base
// - program-counter base equals the extension word's own address
// - index size bit picks low word or full long word of the index
// - scale multiplies index by 1, 2, 4 or 8 for the address only
// - displacements are byte in brief words, word or long in full; outer size comes from indirect select
// - outer displacement applies only in memory-indirect modes
// - no-indirect address is base plus scaled index plus base displacement
// - indirect modes read a pointer at base plus displacement, then add outer
// - preindex adds the scaled index before the pointer is fetched
// - postindex adds the scaled index to the fetched pointer with outer displacement
// - index-suppressed indirect uses pointer plus outer displacement only
// - a word index is sign-extended to 32 bits before scaling
// - word base displacement sign-extends; long is used at full width
// - the intermediate pointer fetch is a long-word read
module ewag_core (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              reqValid,
	output logic                   reqReady,
	input  wire ewag_pkg::ewag_req_s req,
	output logic                   eaValid,
	output logic [31:0]            eaAddr,
	output logic                   memReq,
	output logic [31:0]            memAddr,
	output logic                   memLong,
	input  wire logic              memAck,
	input  wire logic [31:0]       memData,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr
);

	ewag_pkg::ewag_state_s s_q;
	ewag_pkg::ewag_state_s s_d;

	logic [15:0]          ext;
	logic                 fullFmt;
	logic                 pcRel;
	logic                 baseSupp;
	logic                 idxSupp;
	logic [1:0]           scaleUsed;
	logic [2:0]           iis;
	logic                 memInd;
	logic                 postIdx;
	logic                 preIdx;
	logic [31:0]          baseVal;
	logic [31:0]          idxVal;
	logic [31:0]          scaledIdx;
	logic [31:0]          bdVal;
	logic [31:0]          bdRaw;
	logic [31:0]          odVal;
	logic [31:0]          impAddr;
	logic [31:0]          eaNoMem;
	logic [31:0]          eaFinal;
	ewag_pkg::ewag_size_e idxSel;
	ewag_pkg::ewag_size_e bdSel;
	ewag_pkg::ewag_size_e odSel;
	logic                 apbSetup;
	logic                 apbWrite;

	// decode of the latched extension word
	always_comb
	begin
		ext = s_q.req.extWord;
		// an older core does not know the full format and treats it as brief
		fullFmt = ext[`EWAG_EXT_FULL] & ~s_q.legacy;
		pcRel = s_q.req.eaField == `EWAG_EA_PC_REL;
		baseSupp = fullFmt & ext[`EWAG_EXT_BASE_SUPP];
		idxSupp = fullFmt & ext[`EWAG_EXT_IDX_SUPP];
		// zero scale means the same to both cores; legacy drops the rest
		scaleUsed = s_q.legacy ? 2'h0 : ext[10:9];
		iis = fullFmt ? ext[2:0] : 3'h0;
		// brief words carry their own 8-bit displacement in the low byte
		bdRaw = fullFmt ? s_q.req.baseDisplacement
			: {24'h00_0000, ext[7:0]};
		// reserved select codes fall back to no indirection, no trap
		memInd = (iis != 3'h0) & ~(idxSupp & iis[2]);
		postIdx = memInd & ~idxSupp & iis[2];
		preIdx = memInd & ~idxSupp & ~iis[2];
		if (idxSupp)
			idxSel = ewag_pkg::SZ_NULL;
		else if (ext[`EWAG_EXT_IDX_LONG])
			idxSel = ewag_pkg::SZ_LONG;
		else
			idxSel = ewag_pkg::SZ_WORD;
		if (!fullFmt)
			bdSel = ewag_pkg::SZ_BYTE;
		else
		begin
			case (ext[5:4])
				2'h2:    bdSel = ewag_pkg::SZ_WORD;
				2'h3:    bdSel = ewag_pkg::SZ_LONG;
				default: bdSel = ewag_pkg::SZ_NULL;
			endcase
		end
		if (!memInd)
			odSel = ewag_pkg::SZ_NULL;
		else
		begin
			case (iis[1:0])
				2'h2:    odSel = ewag_pkg::SZ_WORD;
				2'h3:    odSel = ewag_pkg::SZ_LONG;
				default: odSel = ewag_pkg::SZ_NULL;
			endcase
		end
	end

	ewag_elem_sizer #(.W(32)) uIdx (
		.raw (s_q.req.indexOperand),
		.sel (idxSel),
		.val (idxVal)
	);

	ewag_elem_sizer #(.W(32)) uBd (
		.raw (bdRaw),
		.sel (bdSel),
		.val (bdVal)
	);

	ewag_elem_sizer #(.W(32)) uOd (
		.raw (s_q.req.outerDisplacement),
		.sel (odSel),
		.val (odVal)
	);

	// the sums all stay 32 bits wide, so any carry out simply drops
	always_comb
	begin
		// program-counter base is the extension word address
		baseVal = pcRel ? s_q.req.extPc : s_q.req.addressRegBase;
		if (baseSupp)
			baseVal = 32'h0000_0000;
		// shift a copy; the index register is never written back
		scaledIdx = idxVal << scaleUsed;
		eaNoMem = baseVal + scaledIdx + bdVal;
		impAddr = baseVal + bdVal + (preIdx ? scaledIdx : 32'h0000_0000);
		eaFinal = memData + odVal + (postIdx ? scaledIdx : 32'h0000_0000);
	end

	assign apbSetup = psel & ~penable;
	assign apbWrite = psel & penable & pwrite;

	always_comb
	begin
		s_d = s_q;
		case (s_q.st)
			ewag_pkg::S_IDLE:
			begin
				if (reqValid && s_q.enable)
				begin
					s_d.req = req;
					s_d.st = ewag_pkg::S_CALC;
				end
			end
			ewag_pkg::S_CALC:
			begin
				s_d.lastInd = memInd;
				if (memInd)
				begin
					s_d.memReq = 1'b1;
					s_d.memAddr = impAddr;
					s_d.st = ewag_pkg::S_FETCH;
				end
				else
				begin
					s_d.ea = eaNoMem;
					s_d.st = ewag_pkg::S_DONE;
				end
			end
			ewag_pkg::S_FETCH:
			begin
				if (memAck)
				begin
					s_d.memReq = 1'b0;
					s_d.intermediate_pointer = memData;
					s_d.ea = eaFinal;
					s_d.st = ewag_pkg::S_DONE;
				end
			end
			ewag_pkg::S_DONE:
			begin
				s_d.doneCnt = s_q.doneCnt + 16'h0001;
				s_d.st = ewag_pkg::S_IDLE;
			end
			default:
			begin
				s_d.memReq = 1'b0;
				s_d.st = ewag_pkg::S_IDLE;
			end
		endcase
		// read data and error are captured in the setup cycle
		if (apbSetup)
		begin
			s_d.slverr = 1'b0;
			case (paddr)
				`EWAG_CTRL_OFS:
					s_d.rdata = {30'h0, s_q.enable, s_q.legacy};
				`EWAG_STATUS_OFS:
					s_d.rdata = {30'h0, s_q.lastInd, s_q.st != ewag_pkg::S_IDLE};
				`EWAG_LAST_EA_OFS:
					s_d.rdata = s_q.ea;
				`EWAG_LAST_IMP_OFS:
					s_d.rdata = s_q.intermediate_pointer;
				`EWAG_DONE_CNT_OFS:
					s_d.rdata = {16'h0000, s_q.doneCnt};
				default:
				begin
					s_d.rdata = 32'h0000_0000;
					s_d.slverr = 1'b1;
				end
			endcase
		end
		// switching legacy mid-calculation would change the decode
		if (apbWrite && paddr == `EWAG_CTRL_OFS)
		begin
			s_d.legacy = pwdata[`EWAG_CTRL_LEGACY_BIT];
			s_d.enable = pwdata[`EWAG_CTRL_ENABLE_BIT];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			s_q <= '0;
			s_q.st <= ewag_pkg::S_IDLE;
			s_q.legacy <= `EWAG_LEGACY_RST;
			s_q.enable <= `EWAG_ENABLE_RST;
		end
		else
			s_q <= s_d;
	end

	assign reqReady = (s_q.st == ewag_pkg::S_IDLE) & s_q.enable;
	assign eaValid = s_q.st == ewag_pkg::S_DONE;
	assign eaAddr = s_q.ea;
	assign memReq = s_q.memReq;
	assign memAddr = s_q.memAddr;
	assign memLong = 1'b1;
	assign prdata = s_q.rdata;
	assign pready = 1'b1;
	assign pslverr = s_q.slverr & psel & penable;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	a_ea_single_pulse: assert property (eaValid |=> !eaValid)
		else $error("result valid held longer than one cycle");

	a_fetch_is_long: assert property (memReq |-> memLong)
		else $error("pointer fetch not a long read");

	a_nomem_no_read: assert property
		(s_q.st == ewag_pkg::S_CALC && !memInd |=> eaValid && !memReq)
		else $error("no-indirect mode touched memory");

	a_nomem_sum: assert property
		(s_q.st == ewag_pkg::S_CALC && !memInd |=> eaAddr == $past(eaNoMem))
		else $error("no-indirect address sum wrong");

	a_imp_address: assert property
		(s_q.st == ewag_pkg::S_CALC && memInd
			|=> memReq && memAddr == $past(impAddr))
		else $error("pointer address wrong");

	a_req_held: assert property
		(memReq && !memAck |=> memReq && $stable(memAddr))
		else $error("pointer request dropped before ack");

	a_final_sum: assert property
		(memReq && memAck |=> eaValid && eaAddr == $past(eaFinal))
		else $error("indirect operand address wrong");

	a_post_index: assert property
		(memReq && memAck && !postIdx
			|=> eaAddr == $past(memData) + $past(odVal))
		else $error("index used outside postindex");

	a_legacy_scale: assert property (s_q.legacy |-> scaledIdx == idxVal)
		else $error("legacy core applied a scale");

	a_base_supp: assert property (baseSupp |-> baseVal == 32'h0000_0000)
		else $error("suppressed base not zero");

	a_od_nomem: assert property (!memInd |-> odVal == 32'h0000_0000)
		else $error("outer displacement used without indirection");

	a_pc_base: assert property
		(pcRel && !baseSupp |-> baseVal == s_q.req.extPc)
		else $error("pc base is not the extension word address");

	a_areg_base: assert property
		(!pcRel && !baseSupp |-> baseVal == s_q.req.addressRegBase)
		else $error("register base not taken from the address register");

	a_idx_word_sext: assert property
		(!idxSupp && !ext[`EWAG_EXT_IDX_LONG]
			|-> idxVal == {{16{s_q.req.indexOperand[15]}},
				s_q.req.indexOperand[15:0]})
		else $error("word index not sign-extended");

	a_idx_long: assert property
		(!idxSupp && ext[`EWAG_EXT_IDX_LONG]
			|-> idxVal == s_q.req.indexOperand)
		else $error("long index not used at full width");

	a_bd_long: assert property
		(fullFmt && ext[5:4] == 2'h3 |-> bdVal == s_q.req.baseDisplacement)
		else $error("long base displacement truncated");

	a_od_word: assert property
		(memInd && iis[1:0] == 2'h2
			|-> odVal == {{16{s_q.req.outerDisplacement[15]}},
				s_q.req.outerDisplacement[15:0]})
		else $error("word outer displacement not sign-extended");

	a_idx_supp: assert property
		(idxSupp |-> idxVal == 32'h0000_0000 && !preIdx && !postIdx)
		else $error("suppressed index still used");

	// brief words never suppress or indirect, whatever the upper bits say
	a_brief_plain: assert property
		(!fullFmt |-> !baseSupp && !idxSupp && !memInd)
		else $error("brief word decoded as full format");

	c_nomem: cover property (s_q.st == ewag_pkg::S_CALC && !memInd);
	c_preindex: cover property (s_q.st == ewag_pkg::S_CALC && preIdx);
	c_postindex: cover property (memReq && memAck && postIdx);
	c_legacy: cover property (s_q.legacy && ext[10:9] != 2'h0 && eaValid);
	c_idx_supp: cover property (s_q.st == ewag_pkg::S_CALC && memInd && idxSupp);

endmodule

// file: ewag_mem_model.sv
`timescale 1ns/1ps
module ewag_mem_model (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        memReq,
	input  wire logic [31:0] memAddr,
	input  wire logic [2:0]  lat,
	output logic             memAck,
	output logic [31:0]      memData
);
	// pointer is a pure function of its address so the bench can predict it
	localparam logic [31:0] PtrKey = 32'h5A3C_96E1;
	logic [2:0] cnt;

	always_ff @(posedge core_clk)
	begin
		if (reset || !memReq || memAck)
		begin
			memAck  <= 1'b0;
			cnt     <= 3'h0;
			// idle bus toggles so stale data never looks like a reply
			memData <= reset ? 32'h0000_0000 : ~memData;
		end
		else if (cnt == lat)
		begin
			memAck  <= 1'b1;
			memData <= memAddr ^ PtrKey;
		end
		else
			cnt <= cnt + 3'h1;
	end
endmodule

// file: test_extension_word_address_generator.sv
`timescale 1ns/1ps
`include "ewag_regs.svh"
module test_extension_word_address_generator;
	localparam logic [31:0] PtrKey = 32'h5A3C_96E1;
	localparam logic [31:0] Zero   = 32'h0000_0000;
	logic                core_clk;
	logic                reset;
	logic                reqValid;
	logic                reqReady;
	logic                eaValid;
	logic                memReq;
	logic                memLong;
	logic                memAck;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic                pready;
	logic                pslverr;
	logic                err;
	logic [2:0]          lat;
	logic [11:0]         paddr;
	logic [31:0]         eaAddr;
	logic [31:0]         memAddr;
	logic [31:0]         memData;
	logic [31:0]         prdata;
	logic [31:0]         pwdata;
	logic [31:0]         rd;
	logic [31:0]         lastEa;
	logic [31:0]         lastImp;
	logic                lastInd;
	logic [31:0]         rnd;
	ewag_pkg::ewag_req_s req;
	ewag_pkg::ewag_req_s r;
	int                  miscompares;
	int                  nTests;
	int                  nReq;

	ewag_core DUT (.core_clk(core_clk), .reset(reset), .reqValid(reqValid),
		.reqReady(reqReady), .req(req), .eaValid(eaValid), .eaAddr(eaAddr),
		.memReq(memReq), .memAddr(memAddr), .memLong(memLong),
		.memAck(memAck), .memData(memData), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	ewag_mem_model mem (.core_clk(core_clk), .reset(reset), .memReq(memReq),
		.memAddr(memAddr), .lat(lat), .memAck(memAck), .memData(memData));

	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	function automatic logic [31:0] sx16(input logic [31:0] v);
		return {{16{v[15]}}, v[15:0]};
	endfunction

	function automatic logic [31:0] expect_ea(input ewag_pkg::ewag_req_s q,
		input logic leg, output logic ind, output logic [31:0] ia);
		logic [15:0] w;
		logic [31:0] b;
		logic [31:0] x;
		logic [31:0] bd;
		logic [31:0] od;
		logic        post;
		w = q.extWord;
		b = (q.eaField == `EWAG_EA_PC_REL) ? q.extPc : q.addressRegBase;
		x = w[11] ? q.indexOperand : sx16(q.indexOperand);
		x = x << (leg ? 2'b00 : w[10:9]);
		ind = 1'b0;
		ia = Zero;
		if (!w[8] || leg)
			return b + x + {{24{w[7]}}, w[7:0]};
		b = w[7] ? Zero : b;
		x = w[6] ? Zero : x;
		bd = w[5] ? (w[4] ? q.baseDisplacement : sx16(q.baseDisplacement)) : Zero;
		od = w[1] ? (w[0] ? q.outerDisplacement : sx16(q.outerDisplacement)) : Zero;
		ind = (w[2:0] != 3'h0) && !(w[6] && w[2]);
		if (!ind)
			return b + x + bd;
		post = !w[6] && w[2];
		ia = b + bd + ((w[6] || post) ? Zero : x);
		return (ia ^ PtrKey) + od + (post ? x : Zero);
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rv, output logic e);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		chk("pready", 32'(pready), 32'h0000_0001);
		rv = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic next_req(output ewag_pkg::ewag_req_s q);
		rnd = xs(rnd);
		q.addressRegBase = rnd;
		rnd = xs(rnd);
		q.indexOperand = rnd;
		rnd = xs(rnd);
		q.baseDisplacement = rnd;
		rnd = xs(rnd);
		q.outerDisplacement = rnd;
		rnd = xs(rnd);
		q.extPc = rnd;
		rnd = xs(rnd);
		q.extWord = rnd[15:0];
		q.eaField = rnd[16] ? `EWAG_EA_PC_REL : rnd[22:17];
		if (q.extWord[7] && q.extWord[6])
			q.extWord[5:4] = 2'b11;
	endtask

	task automatic do_req(input ewag_pkg::ewag_req_s q, input logic leg);
		logic        ind;
		logic        seenMem;
		logic [31:0] ia;
		logic [31:0] ea;
		int          n;
		ea = expect_ea(q, leg, ind, ia);
		seenMem = 1'b0;
		@(posedge core_clk);
		req <= q;
		reqValid <= 1'b1;
		lat <= rnd[26:24];
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (reqReady !== 1'b1 && n < 100);
		reqValid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
			if (memReq === 1'b1 && !seenMem)
			begin
				seenMem = 1'b1;
				chk("memAddr", memAddr, ia);
				chk("memLong", 32'(memLong), 32'h0000_0001);
			end
		end
		while (eaValid !== 1'b1 && n < 100);
		chk("eaValid", 32'(eaValid), 32'h0000_0001);
		chk("indirect", 32'(seenMem), 32'(ind));
		chk("eaAddr", eaAddr, ea);
		lastEa = ea;
		lastInd = ind;
		if (ind)
			lastImp = ia ^ PtrKey;
		nReq++;
	endtask

	task report_and_stop();
		$display("checks %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		report_and_stop();
	end

	initial
	begin
		reset = 1'b1;
		reqValid = 1'b0;
		req = '0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = Zero;
		lat = 3'h0;
		rnd = 32'h0000_E08B;
		lastImp = Zero;
		lastInd = 1'b0;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		apb(1'b0, `EWAG_CTRL_OFS, Zero, rd, err);
		chk("ctrlReset", rd, 32'h0000_0002);
		for (int leg = 0; leg < 2; leg++)
		begin
			apb(1'b1, `EWAG_CTRL_OFS, {30'h0000_0000, 1'b1, leg[0]}, rd, err);
			apb(1'b0, `EWAG_CTRL_OFS, Zero, rd, err);
			chk("ctrl", rd, {30'h0000_0000, 1'b1, leg[0]});
			for (int i = 0; i < 30; i++)
			begin
				next_req(r);
				do_req(r, leg[0]);
			end
		end
		// disabled core must leave a request waiting
		next_req(r);
		apb(1'b1, `EWAG_CTRL_OFS, Zero, rd, err);
		req <= r;
		reqValid <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("reqReady", 32'(reqReady), Zero);
		reqValid <= 1'b0;
		apb(1'b1, `EWAG_CTRL_OFS, 32'h0000_0002, rd, err);
		do_req(r, 1'b0);
		apb(1'b0, `EWAG_DONE_CNT_OFS, Zero, rd, err);
		chk("doneCnt", rd, 32'(nReq));
		apb(1'b0, `EWAG_LAST_EA_OFS, Zero, rd, err);
		chk("lastEa", rd, lastEa);
		apb(1'b1, `EWAG_STATUS_OFS, 32'hFFFF_FFFF, rd, err);
		chk("roWriteErr", 32'(err), Zero);
		apb(1'b0, `EWAG_STATUS_OFS, Zero, rd, err);
		chk("status", rd, {30'h0000_0000, lastInd, 1'b0});
		apb(1'b0, `EWAG_LAST_IMP_OFS, Zero, rd, err);
		chk("lastImp", rd, lastImp);
		apb(1'b0, 12'h0FC, Zero, rd, err);
		chk("unmappedErr", 32'(err), 32'h0000_0001);
		chk("unmappedData", rd, Zero);
		report_and_stop();
	end
endmodule
